// file: dv/axc_drive_model.sv
// drive engine stand-in: answers each start with a done pulse
`timescale 1ns/10ps
module axc_drive_model (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic drive_start_i,
  input  wire logic slow_i,
  output logic      drive_done_o
);
  int cnt_q;
  always @(posedge sys_clk_i)
  begin
    drive_done_o <= 1'h0;
    if (reset_i)
      cnt_q <= 0;
    else if (drive_start_i)
      cnt_q <= slow_i ? 400 : 4;
    else if (cnt_q > 0)
    begin
      cnt_q <= cnt_q - 1;
      drive_done_o <= (cnt_q == 1);
    end
  end
endmodule // axc_drive_model

// file: dv/axc_top_properties.sv
// port assertions for one axis aux block
`timescale 1ns/10ps
module axc_top_properties (
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic       pready_o,
  input wire logic       pslverr_o,
  input wire logic       emergency_stop_input_i,
  input wire logic       drive_done_i,
  input wire logic       drive_start_o,
  input wire logic [7:0] drive_cmd_o,
  input wire logic       drive_stop_o,
  input wire logic       drive_inhibit_o,
  input wire logic       axis_busy_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  property p_rdy;
    psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("no pready after access");
  property p_rdy_one;
    pready_o |=> !pready_o;
  endproperty
  a_rdy_one: assert property (p_rdy_one)
    else $error("pready too long");
  property p_err;
    pslverr_o |-> pready_o;
  endproperty
  a_err: assert property (p_err)
    else $error("pslverr without pready");
  property p_start_one;
    drive_start_o |=> !drive_start_o;
  endproperty
  a_start_one: assert property (p_start_one)
    else $error("start pulse too long");
  property p_cmd_hold;
    !drive_start_o |-> $stable(drive_cmd_o);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold)
    else $error("command moved without start");
  property p_start_busy;
    drive_start_o |=> axis_busy_o;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("not busy after start");
  property p_busy_start;
    drive_start_o |-> !axis_busy_o;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("start while busy");
  property p_done;
    drive_done_i && axis_busy_o |-> ##2 !axis_busy_o;
  endproperty
  a_done: assert property (p_done)
    else $error("busy after done");
  property p_estop;
    emergency_stop_input_i [*4] |=> drive_inhibit_o;
  endproperty
  a_estop: assert property (p_estop)
    else $error("stop input not inhibiting");
  property p_stop_one;
    drive_stop_o |=> !drive_stop_o;
  endproperty
  a_stop_one: assert property (p_stop_one)
    else $error("stop pulse too long");
endmodule // axc_top_properties
bind axc_top axc_top_properties u_axc_top_properties (
  .sys_clk_i, .reset_i, .psel_i, .penable_i, .pready_o, .pslverr_o,
  .emergency_stop_input_i, .drive_done_i, .drive_start_o, .drive_cmd_o,
  .drive_stop_o, .drive_inhibit_o, .axis_busy_o
);

// file: dv/axc_top_tb.sv
// self-checking bench for one axis aux block
`timescale 1ns/10ps
`include "axc_consts.vh"
module axc_top_tb;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] x;
    logic        e;
  } axc_row_t;
  axc_row_t rows [7] = '{
    '{8'h04, 32'hA5A5A5A5, 32'hA5A5A5A5, 1'h0},
    '{8'h18, 32'h0000ABCD, 32'h0000ABCD, 1'h0},
    '{8'h0C, 32'h00000002, 32'h00000002, 1'h0},
    '{8'h0C, 32'h00000000, 32'h00000000, 1'h0},
    '{8'h08, 32'hFFFFFFFF, 32'h003FFFFF, 1'h0},
    '{8'h14, 32'hFFFFFFFF, 32'h00000000, 1'h0},
    '{8'h3C, 32'h00000001, 32'h00000000, 1'h1}
  };
  logic        sys_clk_i = 1'h0;
  logic        reset_i = 1'h1;
  logic        psel_i = 1'h0;
  logic        penable_i = 1'h0;
  logic        pwrite_i = 1'h0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        lim_open = 1'h1;
  logic        manual = 1'h0;
  logic        slow = 1'h1;
  logic [3:0]  src_v = 4'h0;
  logic [5:0]  misc = 6'h00;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  got [16];
  logic [31:0] gotd [16];
  wire  [31:0] prdata;
  wire  [31:0] ddat;
  wire  [7:0]  cmd;
  wire         pready, pslverr, irq, start, stop, chg, inh, gout, busy, done;
  int          err_total = 0;
  int          compares = 0;
  int          n_st = 0, n_stop = 0, n_chg = 0, cyc = 0, i;
  axc_top #(.AXIS_ID(2), .TICK_CYC(2)) u_axc_top (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .plus_limit_input_i(lim_open),
    .minus_limit_input_i(lim_open), .positioning_done_input_i(misc[0]),
    .origin_input_i(misc[1]), .origin_proximity_input_i(misc[2]),
    .encoder_index_input_i(misc[3]), .encoder_phase_inputs_i(misc[5:4]),
    .general_input_line_i({3'h0, src_v[1]}),
    .emergency_stop_input_i(lim_open),
    .multipurpose_sensor_input_i({1'h0, src_v[0]}),
    .manual_mode_i(manual), .axis_status_i({7'h00, src_v[2]}),
    .position_count_i(32'h00000055), .counter_out_i(src_v[3]),
    .drive_done_i(done), .irq_o(irq), .drive_start_o(start),
    .drive_cmd_o(cmd), .drive_data_o(ddat), .drive_stop_o(stop),
    .drive_change_o(chg), .drive_inhibit_o(inh),
    .general_output_line_o(gout), .axis_busy_o(busy)
  );
  axc_drive_model u_axc_drive_model (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .drive_start_i(start),
    .slow_i(slow), .drive_done_o(done)
  );
  initial
    forever #2 sys_clk_i = ~sys_clk_i;
  task automatic give_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, x);
    compares = compares + 1;
    if (s !== x)
    begin
      err_total = err_total + 1;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'h1;
    do
      @(posedge sys_clk_i);
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task automatic pulse(input int k);
    src_v[k] <= 1'h1;
    cy(6);
    src_v[k] <= 1'h0;
    cy(6);
  endtask
  // start log, event counts and hang limit
  always @(posedge sys_clk_i)
  begin
    cyc = cyc + 1;
    misc <= misc + 6'h01;
    if (start === 1'h1)
    begin
      got[n_st] = cmd;
      gotd[n_st] = ddat;
      n_st = n_st + 1;
    end
    if (stop === 1'h1)
      n_stop = n_stop + 1;
    if (chg === 1'h1)
      n_chg = n_chg + 1;
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      give_verdict();
    end
  end
  initial
  begin
    cy(16);
    reset_i <= 1'h0;
    apb(1'h0, `AXC_REG_CFG, 32'h0);
    chk("cfg reset", rd, 32'h18);
    chk("inhibit open", inh, 32'h1);
    lim_open <= 1'h0;
    cy(10);
    chk("inhibit grounded", inh, 32'h0);
    for (i = 0; i < 3; i++)
    begin
      apb(1'h1, `AXC_REG_CFG, 32'h18 | (32'h1 << i));
      cy(10);
      chk("inversion", inh, 32'h1);
    end
    foreach (rows[k])
    begin
      apb(1'h1, rows[k].a, rows[k].w);
      apb(1'h0, rows[k].a, 32'h0);
      chk("read back", rd, rows[k].x);
      chk("slave error", er, rows[k].e);
    end
    apb(1'h1, `AXC_REG_CFG, 32'h18);
    apb(1'h1, `AXC_REG_INT_EN, 32'h7);
    for (i = 1; i < 13; i++)
    begin
      apb(1'h1, `AXC_REG_DATA, i);
      apb(1'h1, `AXC_REG_CMD, i);
    end
    apb(1'h0, `AXC_REG_CMD, 32'h0);
    chk("queue full", rd, 32'h1A);
    apb(1'h0, `AXC_REG_INT_STAT, 32'h0);
    chk("full reject", rd & 32'h4, 32'h4);
    chk("irq on", irq, 32'h1);
    slow <= 1'h0;
    for (i = 0; i < 2000 && n_st < 11; i++)
      cy(1);
    cy(20);
    chk("starts", n_st, 11);
    for (i = 0; i < 11; i++)
    begin
      chk("order", got[i], i + 1);
      chk("data", gotd[i], i + 1);
    end
    apb(1'h0, `AXC_REG_INT_STAT, 32'h0);
    chk("events", rd & 32'h7, 32'h7);
    apb(1'h1, `AXC_REG_INT_EN, 32'h0);
    cy(2);
    chk("irq masked", irq, 32'h0);
    apb(1'h1, `AXC_REG_INT_CLR, 32'hF);
    apb(1'h1, `AXC_REG_INT_EN, 32'hF);
    apb(1'h1, `AXC_REG_CMP, 32'h55);
    cy(3);
    apb(1'h0, `AXC_REG_INT_STAT, 32'h0);
    chk("compare", rd, 32'h8);
    chk("irq compare", irq, 32'h1);
    for (i = 0; i < 3; i++)
    begin
      apb(1'h1, `AXC_REG_CFG, 32'hE08 | ((i + 1) << 4));
      pulse(i);
      chk("stop", n_stop, i + 1);
      chk("change", n_chg, i + 1);
    end
    apb(1'h0, `AXC_REG_LATCH, 32'h0);
    chk("latch", rd, 32'h55);
    manual <= 1'h1;
    apb(1'h1, `AXC_REG_CFG, 32'hA18);
    pulse(0);
    chk("manual", n_stop, 32'h3);
    for (i = 1; i < 3; i++)
    begin
      apb(1'h1, `AXC_REG_CFG, 32'h8 | (i << 17));
      src_v[i + 1] <= 1'h1;
      cy(6);
      chk("gen out", gout, 32'h1);
      src_v[i + 1] <= 1'h0;
      cy(6);
      chk("gen out", gout, 32'h0);
    end
    // compare routing, then a queued entry gated by pause release
    apb(1'h1, `AXC_REG_CFG, 32'h3008);
    cy(2);
    chk("gen out cmp", gout, 32'h1);
    apb(1'h1, `AXC_REG_CTRL, 32'h1);
    apb(1'h1, `AXC_REG_DATA, 32'h77);
    apb(1'h1, `AXC_REG_CMD, 32'h121);
    cy(6);
    apb(1'h0, `AXC_REG_STATUS, 32'h0);
    chk("sync wait", rd & 32'h4000, 32'h4000);
    chk("sync held", n_st, 11);
    apb(1'h1, `AXC_REG_CTRL, 32'h0);
    cy(4);
    chk("sync start", n_st, 12);
    chk("sync cmd", got[11], 32'h21);
    chk("sync data", gotd[11], 32'h77);
    // limits open again: filtered status must lag the pins
    apb(1'h1, `AXC_REG_FILT, 32'h4);
    lim_open <= 1'h1;
    cy(2);
    apb(1'h0, `AXC_REG_STATUS, 32'h0);
    chk("filter short", rd & 32'h3, 32'h0);
    cy(12);
    apb(1'h0, `AXC_REG_STATUS, 32'h0);
    chk("filter long", rd & 32'h3, 32'h3);
    give_verdict();
  end
endmodule // axc_top_tb

// file: logic/axc_consts.vh
// offsets, field positions, reset values and timing for the axis aux block
`ifndef AXC_CONSTS_VH
`define AXC_CONSTS_VH

`define AXC_ADDR_W       8
`define AXC_DATA_W       32

`define AXC_REG_CMD      8'h00
`define AXC_REG_DATA     8'h04
`define AXC_REG_CFG      8'h08
`define AXC_REG_FILT     8'h0C
`define AXC_REG_STATUS   8'h10
`define AXC_REG_LATCH    8'h14
`define AXC_REG_CMP      8'h18
`define AXC_REG_INT_STAT 8'h1C
`define AXC_REG_INT_EN   8'h20
`define AXC_REG_INT_CLR  8'h24
`define AXC_REG_CTRL     8'h28

`define AXC_Q_DEPTH      10
`define AXC_Q_W          41
`define AXC_CMD_SYNC     8

`define AXC_CFG_INV_PLUS   0
`define AXC_CFG_INV_MINUS  1
`define AXC_CFG_INV_ALARM  2
`define AXC_CFG_ALARM_EN   3
`define AXC_CFG_SSRC_LO    4
`define AXC_CFG_SIDX_LO    6
`define AXC_CFG_SF_STOP    9
`define AXC_CFG_SF_LATCH   10
`define AXC_CFG_SF_CHANGE  11
`define AXC_CFG_YSRC_LO    12
`define AXC_CFG_YIDX_LO    14
`define AXC_CFG_OSRC_LO    17
`define AXC_CFG_OIDX_LO    19
`define AXC_CFG_RST        32'h00000008
`define AXC_CFG_MASK       32'h003FFFFF

`define AXC_SRC_NONE     2'h0
`define AXC_SRC_SENSOR   2'h1
`define AXC_SRC_GPIN     2'h2
`define AXC_SRC_STATUS   2'h3
`define AXC_YSRC_SENSOR  2'h0
`define AXC_YSRC_GPIN    2'h1
`define AXC_YSRC_STATUS  2'h2
`define AXC_YSRC_PAUSE   2'h3
`define AXC_OSRC_CMP     2'h0
`define AXC_OSRC_STATUS  2'h1
`define AXC_OSRC_COUNTER 2'h2

`define AXC_INT_DONE     0
`define AXC_INT_QEMPTY   1
`define AXC_INT_QFULL    2
`define AXC_INT_CMP      3
`define AXC_INT_W        4

`define AXC_FILT_RST     4'h0
`define AXC_CLK_NS       4
`define AXC_TICK_NS      1000
`define AXC_TICK_CYC     ((`AXC_TICK_NS + `AXC_CLK_NS - 1) / `AXC_CLK_NS)

`define AXC_IN_W         16
`define AXC_IN_FMASK     16'h0FFF
`define AXC_IN_RST       16'h1003

`endif

// file: logic/axc_filter.v
// two-stage synchroniser and time-constant filter for the axis input pins
`timescale 1ns/10ps
module axc_filter #(
  parameter       W     = 16,
  parameter [W-1:0] FMASK = {W{1'b1}},
  parameter [W-1:0] RST_V = {W{1'b0}}
) (
  input  wire         sys_clk_i,
  input  wire         reset_i,
  input  wire         tick_i,
  input  wire [3:0]   tc_i,
  input  wire [W-1:0] raw_i,
  output reg  [W-1:0] filt_o
);
  reg [W-1:0]   meta_q;
  reg [W-1:0]   sync_q;
  reg [4*W-1:0] cnt_q;
  integer       i;

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      meta_q <= RST_V;
      sync_q <= RST_V;
      cnt_q  <= {(4*W){1'b0}};
      filt_o <= RST_V;
    end
    else
    begin
      meta_q <= raw_i;
      sync_q <= meta_q;
      for (i = 0; i < W; i = i + 1)
      begin
        // masked-off bits and tc 0 pass the synchronised level through
        if (!FMASK[i] || tc_i == 4'h0)
        begin
          filt_o[i]      <= sync_q[i];
          cnt_q[4*i +: 4] <= 4'h0;
        end
        else if (sync_q[i] == filt_o[i])
          cnt_q[4*i +: 4] <= 4'h0;
        else if (tick_i)
        begin
          if (cnt_q[4*i +: 4] >= tc_i - 4'h1)
          begin
            filt_o[i]      <= sync_q[i];
            cnt_q[4*i +: 4] <= 4'h0;
          end
          else
            cnt_q[4*i +: 4] <= cnt_q[4*i +: 4] + 4'h1;
        end
      end
    end
  end
endmodule // axc_filter

// file: logic/axc_top.v
// one axis of auxiliary motion control logic with an APB register slave
//
// Notes on behaviour
// RULE_01: this axis drives its own level interrupt output irq_o.
// RULE_02: drive done, queue drained, queue full and compare match raise irq.
// RULE_03: a ten-entry queue holds pending commands with their data.
// RULE_04: on drive completion the next queued command starts in stored order.
// RULE_05: software queues only general drive commands; others go direct. Here every write to the CMD register is queued, or dropped if the queue is full.
// RULE_06: plus limit, minus limit and alarm inputs have selectable inversion.
// RULE_07: limit, alarm, done, origin, proximity, index, phase inputs filtered.
// RULE_08: sensor event may stop, latch the counter, or trigger drive change.
// RULE_09: sensor event source: sensor input, general input, or axis status.
// RULE_10: general output shows compare result, axis status or counter output.
// RULE_11: sync start waits on sensor, general input, status or pause release.
// RULE_12: status, setting and latched counter read live at any time.
// RULE_13: after reset limits and emergency stop read active when left open.
// RULE_14: after reset sensor 0 feeds axis 3, sensor 1 feeds axis 4.
// RULE_15: in manual mode sensor-input based sensor functions are ignored.
// RULE_16: a command written to a full queue is dropped and flagged.
`timescale 1ns/10ps
`include "axc_consts.vh"
module axc_top #(
  parameter AXIS_ID  = 0,
  parameter TICK_CYC = `AXC_TICK_CYC,
  parameter DEPTH    = `AXC_Q_DEPTH
) (
  input  wire        sys_clk_i,
  input  wire        reset_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire        plus_limit_input_i,
  input  wire        minus_limit_input_i,
  input  wire        positioning_done_input_i,
  input  wire        origin_input_i,
  input  wire        origin_proximity_input_i,
  input  wire        encoder_index_input_i,
  input  wire [1:0]  encoder_phase_inputs_i,
  input  wire [3:0]  general_input_line_i,
  input  wire        emergency_stop_input_i,
  input  wire [1:0]  multipurpose_sensor_input_i,
  input  wire        manual_mode_i,
  input  wire [7:0]  axis_status_i,
  input  wire [31:0] position_count_i,
  input  wire        counter_out_i,
  input  wire        drive_done_i,
  output reg         irq_o,
  output reg         drive_start_o,
  output reg  [7:0]  drive_cmd_o,
  output reg  [31:0] drive_data_o,
  output reg         drive_stop_o,
  output reg         drive_change_o,
  output reg         drive_inhibit_o,
  output reg         general_output_line_o,
  output reg         axis_busy_o
);
  localparam [1:0] AXIS_SEL = AXIS_ID[1:0];
  localparam [3:0] DEPTH_C  = DEPTH[3:0];
  localparam [31:0] CFG_RST =
    (AXIS_ID == 2) ? (`AXC_CFG_RST | 32'h00000010) :
    (AXIS_ID == 3) ? (`AXC_CFG_RST | 32'h00000050) : `AXC_CFG_RST;

  function [3:0] q_inc;
    input [3:0] p;
    begin
      q_inc = (p == DEPTH_C - 4'h1) ? 4'h0 : p + 4'h1;
    end
  endfunction

  // picks one of the four level sources by a two-bit selector
  function src_pick;
    input [1:0] sel;
    input       a;
    input       b;
    input       c;
    input       d;
    begin
      case (sel)
        2'h0:    src_pick = a;
        2'h1:    src_pick = b;
        2'h2:    src_pick = c;
        default: src_pick = d;
      endcase
    end
  endfunction

  reg  [`AXC_Q_W-1:0] q_mem [0:DEPTH-1];
  reg  [3:0]          q_head_q;
  reg  [3:0]          q_tail_q;
  reg  [3:0]          q_cnt_q;
  reg  [31:0]         data_q;
  reg  [31:0]         cfg_q;
  reg  [3:0]          filt_tc_q;
  reg  [31:0]         latch_q;
  reg  [31:0]         cmp_q;
  reg  [`AXC_INT_W-1:0] int_stat_q;
  reg  [`AXC_INT_W-1:0] int_en_q;
  reg                 pause_q;
  reg                 busy_q;
  reg                 cmp_hit_q;
  reg                 sens_lvl_q;
  reg                 sync_lvl_q;
  reg  [8:0]          tick_cnt_q;
  reg                 tick_q;
  reg  [31:0]         rd_d;
  reg                 map_d;
  wire [15:0]         in_f;
  wire [`AXC_Q_W-1:0] q_top = q_mem[q_head_q];

  axc_filter #(
    .W     (`AXC_IN_W),
    .FMASK (`AXC_IN_FMASK),
    .RST_V (`AXC_IN_RST)
  ) u_filter (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .tick_i    (tick_q),
    .tc_i      (filt_tc_q),
    .raw_i     ({manual_mode_i, multipurpose_sensor_input_i,
                 emergency_stop_input_i, general_input_line_i,
                 encoder_phase_inputs_i, encoder_index_input_i,
                 origin_proximity_input_i, origin_input_i,
                 positioning_done_input_i, minus_limit_input_i,
                 plus_limit_input_i}),
    .filt_o    (in_f)
  ); // see RULE_07

  wire [3:0] gp_in   = in_f[11:8];
  wire [1:0] sens_in = in_f[14:13];
  wire       manual  = in_f[15];
  // pin high means open contact; inversion selects normally-open wiring
  wire plus_act  = in_f[0] ^ cfg_q[`AXC_CFG_INV_PLUS];  // see RULE_06
  wire minus_act = in_f[1] ^ cfg_q[`AXC_CFG_INV_MINUS]; // see RULE_06
  wire alarm_act = gp_in[AXIS_SEL] ^ cfg_q[`AXC_CFG_INV_ALARM]; // see RULE_06
  wire estop_act = in_f[12]; // see RULE_13

  wire [1:0] s_src = cfg_q[`AXC_CFG_SSRC_LO +: 2];
  wire [2:0] s_idx = cfg_q[`AXC_CFG_SIDX_LO +: 3];
  wire [1:0] y_src = cfg_q[`AXC_CFG_YSRC_LO +: 2];
  wire [2:0] y_idx = cfg_q[`AXC_CFG_YIDX_LO +: 3];
  wire [1:0] o_src = cfg_q[`AXC_CFG_OSRC_LO +: 2];
  wire [2:0] o_idx = cfg_q[`AXC_CFG_OIDX_LO +: 3];

  // sensor-input source is dead in manual mode
  wire sens_lvl = src_pick(s_src, 1'b0, sens_in[s_idx[0]] & ~manual,
                           gp_in[s_idx[1:0]], axis_status_i[s_idx]);
                           // see RULE_09 // see RULE_15
  wire sens_ev  = sens_lvl & ~sens_lvl_q;
  wire sync_lvl = src_pick(y_src, sens_in[y_idx[0]], gp_in[y_idx[1:0]],
                           axis_status_i[y_idx], ~pause_q); // see RULE_11
  wire sync_ev  = sync_lvl & ~sync_lvl_q;

  wire apb_acc  = psel_i & penable_i;
  wire apb_fire = apb_acc & pready_o;
  wire apb_wr   = apb_fire & pwrite_i;
  wire q_full   = (q_cnt_q == DEPTH_C);
  wire push_req = apb_wr & (paddr_i == `AXC_REG_CMD);
  wire push     = push_req & ~q_full;
  wire q_reject = push_req & q_full; // see RULE_16
  wire q_wait   = (q_cnt_q != 4'h0) & q_top[40];
  wire pop      = ~busy_q & (q_cnt_q != 4'h0) &
                  (~q_top[40] | sync_ev); // see RULE_04 // see RULE_11
  wire cmp_hit  = (position_count_i == cmp_q);
  wire [`AXC_INT_W-1:0] int_ev = {cmp_hit & ~cmp_hit_q, q_reject,
                                  pop & (q_cnt_q == 4'h1),
                                  drive_done_i & busy_q}; // see RULE_02
  wire [31:0] status = {10'h000, cmp_hit, drive_inhibit_o, q_cnt_q,
                        q_full, q_wait, busy_q, manual, sens_in,
                        in_f[7:2], estop_act, alarm_act, minus_act,
                        plus_act};

  always @*
  begin
    rd_d  = 32'h00000000;
    map_d = 1'b1;
    case (paddr_i)
      `AXC_REG_CMD:      rd_d = {27'h0000000, q_full, q_cnt_q};
      `AXC_REG_DATA:     rd_d = data_q;
      `AXC_REG_CFG:      rd_d = cfg_q;
      `AXC_REG_FILT:     rd_d = {28'h0000000, filt_tc_q};
      `AXC_REG_STATUS:   rd_d = status; // see RULE_12
      `AXC_REG_LATCH:    rd_d = latch_q;
      `AXC_REG_CMP:      rd_d = cmp_q;
      `AXC_REG_INT_STAT: rd_d = {28'h0000000, int_stat_q};
      `AXC_REG_INT_EN:   rd_d = {28'h0000000, int_en_q};
      `AXC_REG_INT_CLR:  rd_d = 32'h00000000;
      `AXC_REG_CTRL:     rd_d = {31'h00000000, pause_q};
      default:           map_d = 1'b0;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end
    else if (apb_acc & ~pready_o)
    begin
      pready_o  <= 1'b1;
      pslverr_o <= ~map_d;
      prdata_o  <= pwrite_i ? 32'h00000000 : rd_d;
    end
    else
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      data_q    <= 32'h00000000;
      cfg_q     <= CFG_RST; // see RULE_14
      filt_tc_q <= `AXC_FILT_RST;
      cmp_q     <= 32'h00000000;
      int_en_q  <= {`AXC_INT_W{1'b0}};
      pause_q   <= 1'b0;
    end
    else if (apb_wr)
    begin
      case (paddr_i)
        `AXC_REG_DATA:   data_q    <= pwdata_i;
        `AXC_REG_CFG:    cfg_q     <= pwdata_i & `AXC_CFG_MASK;
        `AXC_REG_FILT:   filt_tc_q <= pwdata_i[3:0];
        `AXC_REG_CMP:    cmp_q     <= pwdata_i;
        `AXC_REG_INT_EN: int_en_q  <= pwdata_i[`AXC_INT_W-1:0];
        `AXC_REG_CTRL:   pause_q   <= pwdata_i[0];
        default:         data_q    <= data_q;
      endcase
    end
  end

  // queue entry: sync flag, command code, data word
  always @(posedge sys_clk_i)
  begin
    if (push)
      q_mem[q_tail_q] <= {pwdata_i[`AXC_CMD_SYNC], pwdata_i[7:0], data_q};
  end

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      q_head_q <= 4'h0;
      q_tail_q <= 4'h0;
      q_cnt_q  <= 4'h0;
      busy_q   <= 1'b0;
    end
    else
    begin
      if (push)
        q_tail_q <= q_inc(q_tail_q); // see RULE_03
      if (pop)
        q_head_q <= q_inc(q_head_q); // see RULE_04
      if (push & ~pop)
        q_cnt_q <= q_cnt_q + 4'h1;
      else if (pop & ~push)
        q_cnt_q <= q_cnt_q - 4'h1;
      if (pop)
        busy_q <= 1'b1;
      else if (drive_done_i)
        busy_q <= 1'b0;
    end
  end

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      int_stat_q            <= {`AXC_INT_W{1'b0}};
      irq_o                 <= 1'b0;
      sens_lvl_q            <= 1'b0;
      sync_lvl_q            <= 1'b0;
      cmp_hit_q             <= 1'b0;
      latch_q               <= 32'h00000000;
      drive_start_o         <= 1'b0;
      drive_cmd_o           <= 8'h00;
      drive_data_o          <= 32'h00000000;
      drive_stop_o          <= 1'b0;
      drive_change_o        <= 1'b0;
      drive_inhibit_o       <= 1'b1;
      general_output_line_o <= 1'b0;
      axis_busy_o           <= 1'b0;
    end
    else
    begin
      // set wins over a clear in the same cycle
      int_stat_q <= (int_stat_q &
                     ~((apb_wr & (paddr_i == `AXC_REG_INT_CLR)) ?
                       pwdata_i[`AXC_INT_W-1:0] : {`AXC_INT_W{1'b0}}))
                    | int_ev; // see RULE_02
      irq_o      <= |(int_stat_q & int_en_q); // see RULE_01
      sens_lvl_q <= sens_lvl;
      sync_lvl_q <= sync_lvl;
      cmp_hit_q  <= cmp_hit;
      if (sens_ev & cfg_q[`AXC_CFG_SF_LATCH])
        latch_q <= position_count_i; // see RULE_08
      drive_stop_o   <= sens_ev & cfg_q[`AXC_CFG_SF_STOP]; // see RULE_08
      drive_change_o <= sens_ev & cfg_q[`AXC_CFG_SF_CHANGE]; // see RULE_08
      drive_start_o  <= pop;
      if (pop)
      begin
        drive_cmd_o  <= q_top[39:32];
        drive_data_o <= q_top[31:0];
      end
      drive_inhibit_o <= plus_act | minus_act | estop_act |
                         (alarm_act & cfg_q[`AXC_CFG_ALARM_EN]); // see RULE_13
      general_output_line_o <= src_pick(o_src, cmp_hit, axis_status_i[o_idx],
                                        counter_out_i, 1'b0); // see RULE_10
      axis_busy_o <= busy_q;
    end
  end

  // filter time base
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      tick_cnt_q <= 9'h000;
      tick_q     <= 1'b0;
    end
    else if (tick_cnt_q == TICK_CYC[8:0] - 9'h001)
    begin
      tick_cnt_q <= 9'h000;
      tick_q     <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 9'h001;
      tick_q     <= 1'b0;
    end
  end
endmodule // axc_top
